// file: clock_cfg_pkg.sv
package clock_cfg_pkg;

  // serial port framing: one direction bit, fifteen address bits, then data bytes
  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] DATA_LAST = 4'h7;

  // register offsets on the configuration port
  localparam logic [14:0] OFS_CONV_CLOCK_POWERDOWN = 15'h0080;
  localparam logic [14:0] OFS_CLOCK_DUTY_CYCLE_CONTROL = 15'h0082;
  localparam logic [14:0] OFS_CLOCK_CROSSING_CONTROL = 15'h0083;
  localparam logic [14:0] OFS_REFERENCE_CLOCK_CONTROL = 15'h0084;
  localparam logic [14:0] OFS_SYSREF_CONTROL_HIGH = 15'h0088;
  localparam logic [14:0] OFS_SYSREF_HYSTERESIS_LOW = 15'h0089;
  localparam logic [14:0] OFS_DELAY_LOOP_POWER_CONTROL = 15'h0090;

  // storage slot of each register
  localparam int NUM_REGS = 7;
  localparam logic [2:0] IDX_PD = 3'h0;
  localparam logic [2:0] IDX_DUTY = 3'h1;
  localparam logic [2:0] IDX_CRS = 3'h2;
  localparam logic [2:0] IDX_REF = 3'h3;
  localparam logic [2:0] IDX_SYS0 = 3'h4;
  localparam logic [2:0] IDX_SYS1 = 3'h5;
  localparam logic [2:0] IDX_DLL = 3'h6;

  // reset values, slot 6 first
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h1f, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h01
  };
  // writable bits; everything else is reserved and reads zero
  localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
    8'h1f, 8'hff, 8'h0f, 8'h31, 8'h8f, 8'hff, 8'h01
  };

  // field positions
  localparam int POS_CONV_PD = 0;
  localparam int POS_DUTY_EN = 7;
  localparam int POS_DUTY_OFFSET_EN = 6;
  localparam int POS_DUTY_BOOST_EN = 5;
  localparam int POS_DUTY_SIGN = 4;
  localparam int POS_CRS_EN = 7;
  localparam int POS_REF_RATE_LO = 4;
  localparam int POS_REF_PD = 0;
  localparam int POS_SYSREF_HYSTERESIS_ENABLE = 3;
  localparam int POS_SYSREF_RISING_EDGE_SELECT = 2;
  localparam int POS_FINE_DC = 4;
  localparam int POS_FINE_XC = 3;
  localparam int POS_COARSE_DC = 2;
  localparam int POS_COARSE_XC = 1;
  localparam int POS_DELAY_LOOP_POWER_CONTROL = 0;

  typedef enum logic [1:0] {
    REF_RATE_X1,
    REF_RATE_X2,
    REF_RATE_X4,
    REF_RATE_OFF
  } ref_rate_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA
  } spi_phase_e;

  // configuration presented to the clock section
  typedef struct packed {
    logic conv_clock_powerdown;
    logic duty_control_enable;
    logic duty_offset_enable;
    logic duty_boost_enable;
    logic duty_offset_negative;
    logic [3:0] duty_offset_code;
    logic crossing_adjust_enable;
    logic [3:0] crossing_point_code;
    ref_rate_e ref_clock_rate;
    logic ref_clock_disabled;
    logic ref_clock_powerdown;
    logic sysref_hysteresis_enable;
    logic sysref_rising_edge_select;
    logic [9:0] sysref_hysteresis_code;
    logic fine_line_duty_correct_enable;
    logic fine_line_cross_enable;
    logic coarse_line_duty_correct_enable;
    logic coarse_line_cross_enable;
    logic delay_loop_powerdown;
  } clk_cfg_s;

  typedef struct packed {
    logic sclk_q;
    spi_phase_e phase;
    logic [3:0] bit_cnt;
    logic [14:0] instr;
    logic rw;
    logic [14:0] addr;
    logic [7:0] shin;
    logic [7:0] shout;
    logic sdo_en;
    logic [NUM_REGS-1:0][7:0] regs;
  } cfg_state_s;

  localparam cfg_state_s STATE_RESET = '{
    sclk_q: 1'b0,
    phase: ST_IDLE,
    bit_cnt: 4'h0,
    instr: 15'h0000,
    rw: 1'b0,
    addr: 15'h0000,
    shin: 8'h00,
    shout: 8'h00,
    sdo_en: 1'b0,
    regs: REG_RESET
  };

endpackage

// file: clock_config_registers.sv
`timescale 1ns/1ps
// Summary of operation
// RL1: converter clock powerdown bit 0 at 0x080 resets to 1; 1 powers down.
// RL2: duty register bit 7 enables duty-cycle control, reset value 1.
// RL3: duty register bit 6 applies the programmed duty offset, reset value 0.
// RL4: duty register bit 5 enables extended duty adjustment range, reset value 0.
// RL5: duty offset bits 4:0 are sign-magnitude, sign on top, reset zero.
// RL6: crossing register: enable bit 7 resets 1, code bits 3:0 reset 0.
// RL7: reference rate bits 5:4: x1, x2, x4, or 11 disables; reset 00.
// RL8: bit 0 at 0x084 powers down the reference clock when 1; reset 0.
// RL9: first sysref register bit 2 selects rising-edge capture, reset 0.
// RL10: first sysref register bit 3 enables receiver hysteresis, reset 0.
// RL11: ten-bit hysteresis code: bits 9:8 in first register, 7:0 in second.
// RL12: delay-loop power register bit 4 enables fine duty correction, reset 1.
// RL13: delay-loop power register bit 3 enables fine cross control, reset 1.
// RL14: bits 2 and 1 enable coarse duty correction and cross control, reset 1.
// RL15: delay-loop power register bit 0 powers down loop and clock generator.
// RL16: reserved bits read as zero; writes to them are dropped.
// RL17: fields drive the clock section continuously; writes act next cycle.
module clock_config_registers
  import clock_cfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_en,
  output clk_cfg_s o_cfg
);

  cfg_state_s state_ff;
  cfg_state_s nxt_state;

  logic sclk_rise;
  logic wr_strobe;
  logic wr_hit;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [14:0] next_addr;
  logic [3:0] lookup;

  // returns {hit, slot}; unmapped offsets miss and read as zero
  function automatic logic [3:0] addr_lookup(input logic [14:0] a);
    logic [3:0] r;
    r = 4'h0;
    unique case (a)
      OFS_CONV_CLOCK_POWERDOWN: r = {1'b1, IDX_PD};
      OFS_CLOCK_DUTY_CYCLE_CONTROL: r = {1'b1, IDX_DUTY};
      OFS_CLOCK_CROSSING_CONTROL: r = {1'b1, IDX_CRS};
      OFS_REFERENCE_CLOCK_CONTROL: r = {1'b1, IDX_REF};
      OFS_SYSREF_CONTROL_HIGH: r = {1'b1, IDX_SYS0};
      OFS_SYSREF_HYSTERESIS_LOW: r = {1'b1, IDX_SYS1};
      OFS_DELAY_LOOP_POWER_CONTROL: r = {1'b1, IDX_DLL};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] read_value(
    input logic [NUM_REGS-1:0][7:0] regs,
    input logic [14:0] a
  );
    logic [3:0] l;
    logic [7:0] v;
    l = addr_lookup(a);
    v = 8'h00;
    if (l[3]) begin
      v = regs[l[2:0]] & REG_MASK[l[2:0]]; // [RL16]
    end
    return v;
  endfunction

  // sclk is slow against i_ref_clk, so an edge is seen by comparing with the
  // previous sample; sdo then moves on the same reference edge that samples sdi,
  // up to one reference cycle after sclk rises, so the master's hold margin is under one reference cycle
  always_comb begin
    nxt_state = state_ff;
    sclk_rise = i_spi_sclk & ~state_ff.sclk_q;
    wr_strobe = 1'b0;
    wr_data = {state_ff.shin[6:0], i_spi_sdi};
    next_addr = state_ff.addr + 15'h0001;
    lookup = addr_lookup(state_ff.addr);
    wr_hit = lookup[3];
    wr_idx = lookup[2:0];
    nxt_state.sclk_q = i_spi_sclk;
    if (i_spi_cs_n) begin
      nxt_state.phase = ST_IDLE;
      nxt_state.bit_cnt = 4'h0;
      nxt_state.sdo_en = 1'b0;
    end else if (sclk_rise) begin
      unique case (state_ff.phase)
        ST_IDLE, ST_INSTR: begin
          nxt_state.phase = ST_INSTR;
          nxt_state.instr = {state_ff.instr[13:0], i_spi_sdi};
          nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          if (state_ff.bit_cnt == INSTR_LAST) begin
            nxt_state.phase = ST_DATA;
            nxt_state.bit_cnt = 4'h0;
            nxt_state.rw = state_ff.instr[14];
            nxt_state.addr = {state_ff.instr[13:0], i_spi_sdi};
            nxt_state.sdo_en = state_ff.instr[14];
            nxt_state.shout = read_value(state_ff.regs, {state_ff.instr[13:0], i_spi_sdi});
          end
        end
        ST_DATA: begin
          nxt_state.shin = wr_data;
          nxt_state.shout = {state_ff.shout[6:0], 1'b0};
          nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          if (state_ff.bit_cnt == DATA_LAST) begin
            // streaming: further bytes go to ascending offsets
            nxt_state.bit_cnt = 4'h0;
            nxt_state.addr = next_addr;
            if (state_ff.rw) begin
              nxt_state.shout = read_value(state_ff.regs, next_addr);
            end else begin
              wr_strobe = 1'b1;
              if (wr_hit) begin
                nxt_state.regs[wr_idx] = wr_data & REG_MASK[wr_idx]; // [RL16] [RL17]
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_ff <= STATE_RESET; // [RL1] [RL2] [RL6] [RL12] [RL13] [RL14] [RL15]
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_spi_sdo = state_ff.shout[7];
  assign o_spi_sdo_en = state_ff.sdo_en;

  // fields wired straight from the register flops, so a write shows up on
  // the cycle after its last data bit and stays there
  always_comb begin
    o_cfg.conv_clock_powerdown = state_ff.regs[IDX_PD][POS_CONV_PD]; // [RL1] [RL17]
    o_cfg.duty_control_enable = state_ff.regs[IDX_DUTY][POS_DUTY_EN]; // [RL2]
    o_cfg.duty_offset_enable = state_ff.regs[IDX_DUTY][POS_DUTY_OFFSET_EN]; // [RL3]
    o_cfg.duty_boost_enable = state_ff.regs[IDX_DUTY][POS_DUTY_BOOST_EN]; // [RL4]
    o_cfg.duty_offset_negative = state_ff.regs[IDX_DUTY][POS_DUTY_SIGN]; // [RL5]
    o_cfg.duty_offset_code = state_ff.regs[IDX_DUTY][3:0]; // [RL5]
    o_cfg.crossing_adjust_enable = state_ff.regs[IDX_CRS][POS_CRS_EN]; // [RL6]
    o_cfg.crossing_point_code = state_ff.regs[IDX_CRS][3:0]; // [RL6]
    o_cfg.ref_clock_rate =
      ref_rate_e'(state_ff.regs[IDX_REF][POS_REF_RATE_LO+1:POS_REF_RATE_LO]); // [RL7]
    o_cfg.ref_clock_disabled =
      &state_ff.regs[IDX_REF][POS_REF_RATE_LO+1:POS_REF_RATE_LO]; // [RL7]
    o_cfg.ref_clock_powerdown = state_ff.regs[IDX_REF][POS_REF_PD]; // [RL8]
    o_cfg.sysref_hysteresis_enable = state_ff.regs[IDX_SYS0][POS_SYSREF_HYSTERESIS_ENABLE]; // [RL10]
    o_cfg.sysref_rising_edge_select = state_ff.regs[IDX_SYS0][POS_SYSREF_RISING_EDGE_SELECT]; // [RL9]
    o_cfg.sysref_hysteresis_code =
      {state_ff.regs[IDX_SYS0][1:0], state_ff.regs[IDX_SYS1]}; // [RL11]
    o_cfg.fine_line_duty_correct_enable = state_ff.regs[IDX_DLL][POS_FINE_DC]; // [RL12]
    o_cfg.fine_line_cross_enable = state_ff.regs[IDX_DLL][POS_FINE_XC]; // [RL13]
    o_cfg.coarse_line_duty_correct_enable = state_ff.regs[IDX_DLL][POS_COARSE_DC]; // [RL14]
    o_cfg.coarse_line_cross_enable = state_ff.regs[IDX_DLL][POS_COARSE_XC]; // [RL14]
    o_cfg.delay_loop_powerdown = state_ff.regs[IDX_DLL][POS_DELAY_LOOP_POWER_CONTROL]; // [RL15]
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic wr_go;
  assign wr_go = wr_strobe & wr_hit;

  a_conv_pd_reset: assert property ( // [RL1]
    $rose(i_rst_n) |-> o_cfg.conv_clock_powerdown
  ) else $error("converter clock not powered down after reset");

  a_conv_pd_write: assert property ( // [RL1]
    wr_go && wr_idx == IDX_PD |=> o_cfg.conv_clock_powerdown == $past(wr_data[0])
  ) else $error("converter clock powerdown did not follow write");

  a_duty_reset_state: assert property ( // [RL2]
    $rose(i_rst_n) |-> o_cfg.duty_control_enable && !o_cfg.duty_offset_enable
  ) else $error("duty control reset state wrong");

  a_boost_reset_off: assert property ( // [RL4]
    $rose(i_rst_n) |-> !o_cfg.duty_boost_enable && !o_cfg.duty_offset_negative
  ) else $error("duty boost or sign not clear after reset");

  a_duty_offset_decode: assert property ( // [RL5]
    wr_go && wr_idx == IDX_DUTY |=>
      o_cfg.duty_offset_negative == $past(wr_data[4]) &&
      o_cfg.duty_offset_code == $past(wr_data[3:0]) &&
      o_cfg.duty_offset_enable == $past(wr_data[6])
  ) else $error("duty offset fields do not match written byte");

  a_crossing_reserved_zero: assert property ( // [RL6]
    state_ff.regs[IDX_CRS][6:4] == 3'h0
  ) else $error("crossing register reserved bits not zero");

  a_ref_rate_disable: assert property ( // [RL7]
    wr_go && wr_idx == IDX_REF && wr_data[5:4] == 2'b11 |=>
      o_cfg.ref_clock_disabled && o_cfg.ref_clock_rate == REF_RATE_OFF
  ) else $error("reference rate 11 did not disable the clock");

  a_ref_pd_reset: assert property ( // [RL8]
    $rose(i_rst_n) |-> !o_cfg.ref_clock_powerdown && o_cfg.ref_clock_rate == REF_RATE_X1
  ) else $error("reference clock control reset state wrong");

  a_sysref_ctrl_write: assert property ( // [RL9]
    wr_go && wr_idx == IDX_SYS0 |=>
      o_cfg.sysref_rising_edge_select == $past(wr_data[2]) &&
      o_cfg.sysref_hysteresis_enable == $past(wr_data[3])
  ) else $error("sysref edge or hysteresis enable did not follow write");

  a_hys_low_split: assert property ( // [RL11]
    wr_go && wr_idx == IDX_SYS1 |=>
      o_cfg.sysref_hysteresis_code[7:0] == $past(wr_data) &&
      $stable(o_cfg.sysref_hysteresis_code[9:8])
  ) else $error("hysteresis low byte not placed in bits 7:0");

  a_dll_reset_enables: assert property ( // [RL12]
    $rose(i_rst_n) |-> o_cfg.fine_line_duty_correct_enable && o_cfg.fine_line_cross_enable &&
      o_cfg.coarse_line_duty_correct_enable && o_cfg.coarse_line_cross_enable &&
      o_cfg.delay_loop_powerdown
  ) else $error("delay loop power register reset state wrong");

  a_reserved_read_zero: assert property ( // [RL16]
    sclk_rise && !i_spi_cs_n && state_ff.phase == ST_DATA &&
      state_ff.bit_cnt == DATA_LAST && state_ff.rw |=>
      !lookup[3] || (state_ff.shout & ~REG_MASK[lookup[2:0]]) == 8'h00
  ) else $error("reserved bits read back nonzero");

  a_regs_hold_idle: assert property ( // [RL17]
    !wr_go |=> $stable(state_ff.regs)
  ) else $error("register changed without a write");

  a_write_one_cycle: assert property ( // [RL17]
    wr_go && ((wr_data & REG_MASK[wr_idx]) != state_ff.regs[wr_idx]) |=>
      $changed(state_ff.regs) ##1 $stable(state_ff.regs) [*2]
  ) else $error("write did not land exactly on the next cycle");

  // field tracking: every field follows the byte last written to its slot
  a_duty_write_enables: assert property ( // [RL2] [RL4]
    wr_go && wr_idx == IDX_DUTY |=>
      o_cfg.duty_control_enable == $past(wr_data[7]) &&
      o_cfg.duty_boost_enable == $past(wr_data[5])
  ) else $error("duty enables did not follow write");

  a_crossing_write_fields: assert property ( // [RL6]
    wr_go && wr_idx == IDX_CRS |=>
      o_cfg.crossing_adjust_enable == $past(wr_data[7]) &&
      o_cfg.crossing_point_code == $past(wr_data[3:0])
  ) else $error("crossing fields did not follow write");

  a_crossing_reset_state: assert property ( // [RL6]
    $rose(i_rst_n) |-> o_cfg.crossing_adjust_enable && o_cfg.crossing_point_code == 4'h0
  ) else $error("crossing register reset state wrong");

  a_ref_rate_write: assert property ( // [RL7]
    wr_go && wr_idx == IDX_REF |=>
      o_cfg.ref_clock_rate == ref_rate_e'($past(wr_data[5:4])) &&
      o_cfg.ref_clock_disabled == (&$past(wr_data[5:4]))
  ) else $error("reference rate did not follow write");

  a_ref_pd_write: assert property ( // [RL8]
    wr_go && wr_idx == IDX_REF |=> o_cfg.ref_clock_powerdown == $past(wr_data[0])
  ) else $error("reference clock powerdown did not follow write");

  a_sysref_reset_state: assert property ( // [RL9] [RL10] [RL11]
    $rose(i_rst_n) |-> !o_cfg.sysref_rising_edge_select && !o_cfg.sysref_hysteresis_enable &&
      o_cfg.sysref_hysteresis_code == 10'h000
  ) else $error("sysref control reset state wrong");

  a_hys_high_split: assert property ( // [RL11]
    wr_go && wr_idx == IDX_SYS0 |=>
      o_cfg.sysref_hysteresis_code[9:8] == $past(wr_data[1:0]) &&
      $stable(o_cfg.sysref_hysteresis_code[7:0])
  ) else $error("hysteresis high bits not placed in bits 9:8");

  a_fine_line_write: assert property ( // [RL12] [RL13]
    wr_go && wr_idx == IDX_DLL |=>
      o_cfg.fine_line_duty_correct_enable == $past(wr_data[4]) &&
      o_cfg.fine_line_cross_enable == $past(wr_data[3])
  ) else $error("fine line enables did not follow write");

  a_coarse_line_write: assert property ( // [RL14]
    wr_go && wr_idx == IDX_DLL |=>
      o_cfg.coarse_line_duty_correct_enable == $past(wr_data[2]) &&
      o_cfg.coarse_line_cross_enable == $past(wr_data[1])
  ) else $error("coarse line enables did not follow write");

  a_loop_pd_write: assert property ( // [RL15]
    wr_go && wr_idx == IDX_DLL |=> o_cfg.delay_loop_powerdown == $past(wr_data[0])
  ) else $error("delay loop powerdown did not follow write");

  a_reserved_store_zero: assert property ( // [RL16]
    state_ff.regs[IDX_PD][7:1] == 7'h00 && state_ff.regs[IDX_REF][7:6] == 2'h0 &&
      state_ff.regs[IDX_REF][3:1] == 3'h0 && state_ff.regs[IDX_SYS0][7:4] == 4'h0 &&
      state_ff.regs[IDX_DLL][7:5] == 3'h0
  ) else $error("reserved bits held nonzero");

  a_write_masked_store: assert property ( // [RL16]
    wr_go |=> (state_ff.regs[$past(wr_idx)] & ~REG_MASK[$past(wr_idx)]) == 8'h00
  ) else $error("write stored into reserved bits");

  a_unmapped_write_drop: assert property ( // [RL16]
    wr_strobe && !wr_hit |=> $stable(state_ff.regs)
  ) else $error("write to unmapped offset changed a register");

  a_duty_code_reset: assert property ( // [RL5]
    $rose(i_rst_n) |-> o_cfg.duty_offset_code == 4'h0 && !o_cfg.duty_offset_negative
  ) else $error("duty offset not zero after reset");

  // a read of an unmapped offset must still drive the port, with zeros
  a_unmapped_read_zero: assert property ( // [RL16]
    sclk_rise && !i_spi_cs_n && state_ff.phase == ST_INSTR &&
      state_ff.bit_cnt == INSTR_LAST && state_ff.instr[14] |=>
      o_spi_sdo_en && (lookup[3] || state_ff.shout == 8'h00)
  ) else $error("read frame did not enable sdo or unmapped read nonzero");

  a_read_release: assert property ( // [RL16]
    i_spi_cs_n |=> !o_spi_sdo_en
  ) else $error("sdo still driven after select released");

  c_write_then_read: cover property (
    wr_go ##[1:200] (state_ff.phase == ST_DATA && state_ff.rw && o_spi_sdo_en)
  );

  c_unmapped_write: cover property (
    wr_strobe && !wr_hit
  );

  c_streamed_writes: cover property (
    wr_go ##[1:100] wr_go
  );

  c_ref_clock_off: cover property (
    o_cfg.ref_clock_disabled
  );

  c_cut_frame: cover property (
    state_ff.phase == ST_DATA && state_ff.bit_cnt != 4'h0 && i_spi_cs_n
  );

endmodule

// file: clock_config_registers_tb.sv
`timescale 1ns/1ps
module clock_config_registers_tb
  import clock_cfg_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_spi_cs_n = 1'b1;
  logic i_spi_sclk = 1'b0;
  logic i_spi_sdi = 1'b0;
  logic o_spi_sdo;
  logic o_spi_sdo_en;
  clk_cfg_s o_cfg;
  int mismatches = 0;
  int n_checks = 0;
  integer seed = 71;
  logic [7:0] shadow [7];
  logic [14:0] offs [7] = '{OFS_CONV_CLOCK_POWERDOWN, OFS_CLOCK_DUTY_CYCLE_CONTROL,
    OFS_CLOCK_CROSSING_CONTROL, OFS_REFERENCE_CLOCK_CONTROL, OFS_SYSREF_CONTROL_HIGH,
    OFS_SYSREF_HYSTERESIS_LOW, OFS_DELAY_LOOP_POWER_CONTROL};
  logic [7:0] rst_val [7] = '{8'h01, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1f};
  logic [7:0] wmask [7] = '{8'h01, 8'hff, 8'h8f, 8'h31, 8'h0f, 8'hff, 8'h1f};

  clock_config_registers clock_config_registers_inst (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_sclk(i_spi_sclk),
    .i_spi_sdi(i_spi_sdi),
    .o_spi_sdo(o_spi_sdo),
    .o_spi_sdo_en(o_spi_sdo_en),
    .o_cfg(o_cfg)
  );

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic clk_cfg_s exp_cfg();
    clk_cfg_s c;
    c.conv_clock_powerdown = shadow[0][0];
    c.duty_control_enable = shadow[1][7];
    c.duty_offset_enable = shadow[1][6];
    c.duty_boost_enable = shadow[1][5];
    c.duty_offset_negative = shadow[1][4];
    c.duty_offset_code = shadow[1][3:0];
    c.crossing_adjust_enable = shadow[2][7];
    c.crossing_point_code = shadow[2][3:0];
    c.ref_clock_rate = ref_rate_e'(shadow[3][5:4]);
    c.ref_clock_disabled = &shadow[3][5:4];
    c.ref_clock_powerdown = shadow[3][0];
    c.sysref_hysteresis_enable = shadow[4][3];
    c.sysref_rising_edge_select = shadow[4][2];
    c.sysref_hysteresis_code = {shadow[4][1:0], shadow[5]};
    c.fine_line_duty_correct_enable = shadow[6][4];
    c.fine_line_cross_enable = shadow[6][3];
    c.coarse_line_duty_correct_enable = shadow[6][2];
    c.coarse_line_cross_enable = shadow[6][1];
    c.delay_loop_powerdown = shadow[6][0];
    return c;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // half period of five reference cycles keeps the edge detector well clear of its limit
  task automatic sbit(input logic b, output logic got);
    i_spi_sclk = 1'b0;
    i_spi_sdi = b;
    cycles(5);
    got = o_spi_sdo;
    i_spi_sclk = 1'b1;
    cycles(5);
  endtask

  // nbits below 24 cuts the frame short to test the abort path
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                       input int nbits, output logic [7:0] q);
    logic [23:0] w;
    logic g;
    w = {rd, a, wd};
    q = 8'h00;
    i_spi_cs_n = 1'b0;
    cycles(2);
    for (int i = 23; i >= 24 - nbits; i--) begin
      sbit(w[i], g);
      if (i < 8) begin
        q = {q[6:0], g};
      end
      if (i == 7) begin
        check(64'(o_spi_sdo_en), 64'(rd), "sdo drive enable in data phase");
      end
    end
    i_spi_sclk = 1'b0;
    cycles(3);
    i_spi_cs_n = 1'b1;
    cycles(3);
    check(64'(o_spi_sdo_en), 64'h0, "sdo drive released");
  endtask

  task automatic wr(input int k, input logic [7:0] d);
    logic [7:0] q;
    frame(1'b0, offs[k], d, 24, q);
    shadow[k] = d & wmask[k];
  endtask

  task automatic rd_check(input int k);
    logic [7:0] q;
    frame(1'b1, offs[k], 8'h00, 24, q);
    check(64'(q), 64'(shadow[k]), "register readback");
  endtask

  task automatic check_cfg();
    clk_cfg_s e;
    e = exp_cfg();
    check(64'(o_cfg[34:26]), 64'(e[34:26]), "power and duty fields");
    check(64'(o_cfg[25:17]), 64'(e[25:17]), "crossing and reference");
    check(64'(o_cfg[16:5]), 64'(e[16:5]), "sysref fields");
    check(64'(o_cfg[4:0]), 64'(e[4:0]), "delay loop fields");
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] d;
    int k;
    cycles(12);
    i_rst_n = 1'b1;
    shadow = rst_val;
    check_cfg();
    for (int i = 0; i < 7; i++) begin
      rd_check(i);
    end
    // every bit set then cleared, so reserved bits and each field are seen both ways
    for (int i = 0; i < 7; i++) begin
      wr(i, 8'hff);
      check_cfg();
      rd_check(i);
      wr(i, 8'h00);
      check_cfg();
      rd_check(i);
    end
    for (int r = 0; r < 4; r++) begin
      wr(3, {2'b00, r[1:0], 3'b000, r[0]});
      check_cfg();
      check(64'(o_cfg.ref_clock_disabled), 64'(r == 3), "reference disable");
    end
    wr(1, 8'h5f);
    check(64'(o_cfg.duty_offset_negative), 64'h1, "duty sign");
    check(64'(o_cfg.duty_offset_code), 64'hf, "duty magnitude");
    wr(4, 8'h02);
    wr(5, 8'h5a);
    check(64'(o_cfg.sysref_hysteresis_code), 64'h25a, "hysteresis code");
    frame(1'b0, 15'h0081, 8'hff, 24, q);
    frame(1'b1, 15'h0081, 8'h00, 24, q);
    check(64'(q), 64'h0, "unmapped readback");
    check_cfg();
    frame(1'b0, offs[1], 8'ha5, 20, q);
    check_cfg();
    repeat (40) begin
      k = $unsigned($random(seed)) % 7;
      d = 8'($random(seed));
      wr(k, d);
      check_cfg();
      rd_check(k);
    end
    i_rst_n = 1'b0;
    cycles(2);
    shadow = rst_val;
    check_cfg();
    i_rst_n = 1'b1;
    cycles(2);
    check_cfg();
    rd_check(6);
    tally_and_finish();
  end

  // about 130 frames of 250 cycles each are expected
  initial begin
    cycles(70000);
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
